// ===== logic/cmd_slave.sv
// two-wire serial slave engine for command-code transactions
// assumes pins are asynchronous; read data supplied by the register set
// Behaviour
// - ack own address in its slot
// - address, clear-faults command (03), stop clears faults
// - repeated start after command allows read
// - write byte: command plus one byte acked
// - write word: command plus two bytes acked
// - block write: count then N bytes acked
// - read byte: ack, one byte, master nacks
// - read word: low byte first, then high
// - block read: count then data bytes
// - ack read address before driving data
// - 35 ms idle with guard releases bus
// - config bit 3 enables guard, reset off
// - command selects byte count per transfer
// - clear faults pulses clear, refaults reappear
`timescale 1ns/1ps
module cmd_slave #(
	parameter logic [6:0] DEV_ADDR = cmd_slave_pkg::DEV_ADDR_DEFAULT,
	parameter int GUARD_CYC = cmd_slave_pkg::GUARD_CYCLES,
	parameter int DEPTH = cmd_slave_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] rd_cmd,
	output logic [7:0] rd_index,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] rd_len,
	output logic [23:0] wr_beat,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic clear_faults,
	output logic [7:0] cfg_one,
	output logic guard_tripped
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_WRX,
		ST_TX,
		ST_TXACK,
		ST_IGNORE
	} st_e;

	logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen, any_edge;
	bus_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl(scl),
		.sda(sda),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.any_edge(any_edge)
	);

	st_e st_q, st_d;
	logic [7:0] sh_q, sh_d, cmd_q, cmd_d, idx_q, idx_d, cfg_q, cfg_d;
	logic [3:0] bit_q, bit_d;
	logic rd_q, rd_d, ackdrv_q, ackdrv_d, sda_oe_q, sda_oe_d, sda_out_q, sda_out_d;
	logic clr_q, clr_d, trip_q, trip_d, naccnt_q, naccnt_d;
	logic [31:0] guard_q, guard_d;
	logic [23:0] fifo_out;
	logic fin_valid, fin_ready, fout_valid;
	cmd_slave_pkg::wr_beat_s beat;
	logic guard_on, expire;

	assign guard_on = cfg_q[cmd_slave_pkg::GUARD_EN_BIT];
	assign expire = guard_on && st_q != ST_IDLE && guard_q >= 32'(GUARD_CYC - 1);

	assign beat.cmd = cmd_q;
	assign beat.data = sh_q;
	assign beat.index = idx_q;
	// push the completed write byte (not the command) on the ack edge
	// address (FE) and command (FF) slots are never buffered
	assign fin_valid = st_q == ST_ACK && scl_fall && !rd_q && bit_q == 4'h8 && idx_q < 8'hFE;

	beat_fifo #(.WIDTH(24), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(beat),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.out_data(fifo_out),
		.out_valid(fout_valid),
		.out_ready(wr_ready)
	);

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cmd_d = cmd_q;
		idx_d = idx_q;
		bit_d = bit_q;
		rd_d = rd_q;
		ackdrv_d = ackdrv_q;
		sda_oe_d = sda_oe_q;
		sda_out_d = 1'b0;
		clr_d = 1'b0;
		trip_d = 1'b0;
		naccnt_d = naccnt_q;
		cfg_d = cfg_q;
		guard_d = (any_edge || st_q == ST_IDLE) ? '0 : guard_q + 32'h1;
		if (expire) begin
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
			trip_d = 1'b1;
		end else if (start_seen) begin
			// repeated start keeps the loaded command pointer
			st_d = ST_ADDR;
			bit_d = '0;
			sda_oe_d = 1'b0;
		end else if (stop_seen) begin
			// a command with no data before stop is a send byte
			if (st_q != ST_IGNORE && !rd_q && idx_q == 8'h00
				&& cmd_q == cmd_slave_pkg::CMD_CLEAR_FAULTS) begin
				clr_d = 1'b1;
			end
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					rd_d = 1'b0;
					idx_d = 8'hFE;
				end
				ST_ADDR: if (scl_rise) begin
					sh_d = {sh_q[6:0], sda};
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						if (sh_q[6:0] == DEV_ADDR) begin
							rd_d = sda;
							st_d = ST_ACK;
						end else begin
							st_d = ST_IGNORE;
						end
					end
				end
				ST_WRX: if (scl_rise) begin
					sh_d = {sh_q[6:0], sda};
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						st_d = ST_ACK;
					end
				end
				ST_ACK: if (scl_fall) begin
					if (bit_q == 4'h8) begin
						// drive ack low for the ninth clock unless a data byte finds the buffer full
						sda_oe_d = fin_ready || idx_q >= 8'hFE || rd_q;
						bit_d = 4'h9;
						if (!rd_q && idx_q == 8'hFF) begin
							cmd_d = sh_q;
						end
						if (!rd_q) begin
							idx_d = idx_q + 8'h1;
						end
					end else begin
						sda_oe_d = 1'b0;
						bit_d = '0;
						if (rd_q) begin
							// ack of read address done, now drive data
							idx_d = '0;
							sh_d = rd_data;
							sda_oe_d = !rd_data[7];
							st_d = ST_TX;
						end else begin
							st_d = ST_WRX;
						end
					end
				end
				ST_TX: if (scl_fall) begin
					bit_d = bit_q + 4'h1;
					if (bit_q == 4'h7) begin
						sda_oe_d = 1'b0;
						st_d = ST_TXACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						sda_oe_d = !sh_q[6];
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						naccnt_d = sda;
					end
					if (scl_fall) begin
						if (naccnt_q || idx_q + 8'h1 >= rd_len) begin
							// nack or length done: release and wait for stop
							st_d = ST_IGNORE;
						end else begin
							// next byte of word or block, low byte first
							idx_d = idx_q + 8'h1;
							sh_d = rd_data;
							bit_d = '0;
							sda_oe_d = !rd_data[7];
							st_d = ST_TX;
						end
					end
				end
				ST_IGNORE: sda_oe_d = 1'b0;
				default: st_d = ST_IDLE;
			endcase
		end
	end

	// sdd: rd_index is the pointer plus one in the read ack slot, zero otherwise
	assign rd_cmd = cmd_q;
	assign rd_index = (st_q == ST_TXACK) ? idx_q + 8'h1 : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			sh_q <= '0;
			cmd_q <= '0;
			idx_q <= 8'hFE;
			bit_q <= '0;
			rd_q <= 1'b0;
			ackdrv_q <= 1'b0;
			sda_oe_q <= 1'b0;
			sda_out_q <= 1'b0;
			clr_q <= 1'b0;
			trip_q <= 1'b0;
			naccnt_q <= 1'b0;
			cfg_q <= cmd_slave_pkg::CFG_ONE_RESET;
			guard_q <= '0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			cmd_q <= cmd_d;
			idx_q <= idx_d;
			bit_q <= bit_d;
			rd_q <= rd_d;
			ackdrv_q <= ackdrv_d;
			sda_oe_q <= sda_oe_d;
			sda_out_q <= sda_out_d;
			clr_q <= clr_d;
			trip_q <= trip_d;
			naccnt_q <= naccnt_d;
			cfg_q <= (fout_valid && wr_ready && fifo_out[23:16] == cmd_slave_pkg::CFG_ONE_OFFSET
				&& fifo_out[7:0] == 8'h00) ? fifo_out[15:8] : cfg_d;
			guard_q <= guard_d;
		end
	end

	assign sda_out = sda_out_q;
	assign sda_oe = sda_oe_q;
	assign clear_faults = clr_q;
	assign cfg_one = cfg_q;
	assign guard_tripped = trip_q;
	assign wr_beat = fifo_out;
	assign wr_valid = fout_valid;

	AST_GUARD_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		!guard_on |-> !trip_q) else $error("guard fired while disabled");
	AST_GUARD_REL: assert property (@(posedge clk) disable iff (!rst_n)
		trip_q |-> !sda_oe_q && st_q == ST_IDLE) else $error("bus not released");
	AST_CLR_STOP: assert property (@(posedge clk) disable iff (!rst_n)
		clr_q |-> $past(stop_seen) && cmd_q == cmd_slave_pkg::CMD_CLEAR_FAULTS)
		else $error("clear without send byte");
	sequence addr_hit;
		st_q == ST_ADDR ##1 st_q == ST_ACK;
	endsequence
	AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rst_n)
		addr_hit |-> !sda_oe_q until (bit_q == 4'h9)) else $error("early ack");
	AST_TX_AFTER_ACK: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_q == ST_TX) && idx_q == 8'h00 |-> $past(st_q) == ST_ACK)
		else $error("read data before address ack");
	AST_NO_DRIVE_IGN: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_IGNORE ##1 st_q == ST_IGNORE |-> !sda_oe_q) else $error("drive in ignore");
	AST_CMD_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(cmd_q) |-> $past(st_q) == ST_ACK) else $error("pointer loaded off ack");
	AST_OUT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		!sda_out_q) else $error("sda output not low");
endmodule

// ===== logic/cmd_slave_pkg.sv
// shared constants and carrier types for the two-wire command slave
// assumes a 100 MHz system clock
package cmd_slave_pkg;
	localparam logic [7:0] CFG_ONE_OFFSET = 8'hD1;
	localparam int GUARD_EN_BIT = 3;
	localparam logic [7:0] CFG_ONE_RESET = 8'h00;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20; // arbitrary
	localparam int CLK_MHZ = 100;
	localparam int GUARD_MS = 35;
	localparam int GUARD_CYCLES = GUARD_MS * 1000 * CLK_MHZ;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		XFER_DATA,
		XFER_COUNT,
		XFER_FIRST
	} xfer_kind_e;

	// one received write byte with its position in the transaction
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
		logic [7:0] index;
	} wr_beat_s;
endpackage

// ===== logic/beat_fifo.sv
// flop-based first-in first-out buffer with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module beat_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;

	assign in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
	assign out_valid = wp_q != rp_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rp_q[AW-1:0]];

	always_comb begin
		wp_d = wp_q + (AW+1)'(push);
		rp_d = rp_q + (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// storage has no reset; only written slots are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end
endmodule

// ===== logic/bus_sync.sv
// two-flop synchroniser and edge detection for the serial clock and data pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module bus_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl,
	output logic sda,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen,
	output logic any_edge
);
	logic [1:0] m1_q, m1_d, m2_q, m2_d, m3_q, m3_d;

	always_comb begin
		m1_d = {scl_in, sda_in};
		m2_d = m1_q;
		m3_d = m2_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m1_q <= 2'h3;
			m2_q <= 2'h3;
			m3_q <= 2'h3;
		end else begin
			m1_q <= m1_d;
			m2_q <= m2_d;
			m3_q <= m3_d;
		end
	end

	assign scl = m2_q[1];
	assign sda = m2_q[0];
	assign scl_rise = m2_q[1] && !m3_q[1];
	assign scl_fall = !m2_q[1] && m3_q[1];
	assign start_seen = m2_q[1] && m3_q[1] && !m2_q[0] && m3_q[0];
	assign stop_seen = m2_q[1] && m3_q[1] && m2_q[0] && !m3_q[0];
	assign any_edge = m2_q != m3_q;
endmodule

// ===== tb/bus_master.sv
// two-wire bus master model driving scl and pulling or releasing data
// assumes sda is the resolved wire with a pull-up
`timescale 1ns/1ps
module bus_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl_q,
	output logic sda_q
);
	initial begin
		scl_q = 1'b1;
		sda_q = 1'b1;
	end
	task automatic set(input logic c, input logic d);
		@(posedge clk);
		scl_q <= c;
		sda_q <= d;
		repeat (7) @(posedge clk);
	endtask
	// data moves one step after the fall, never with it
	task automatic bit_io(input logic d, output logic r);
		set(1'b0, sda_q);
		set(1'b0, d);
		set(1'b1, d);
		r = sda;
	endtask
	task automatic start();
		set(1'b0, sda_q);
		set(1'b0, 1'b1);
		set(1'b1, 1'b1);
		set(1'b1, 1'b0);
	endtask
	task automatic stop();
		set(1'b0, sda_q);
		set(1'b0, 1'b0);
		set(1'b1, 1'b0);
		set(1'b1, 1'b1);
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(nack, r);
	endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the two-wire command slave
// assumes bus_master as far side; register set modelled here
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr_ready = 1'b1;
	logic scl, sda_m, sda_out, sda_oe, clear_faults, wr_valid, guard_tripped, ack;
	logic [7:0] rd_cmd, rd_index, rd_len, cfg_one, b;
	logic [23:0] wr_beat;
	logic [23:0] beats[$];
	int miscompares = 0;
	int checks = 0;
	int clears = 0;
	int trips = 0;
	int k;
	wire logic sda = sda_m & ~(sda_oe & ~sda_out);
	always #5 clk = ~clk;
	function automatic logic [7:0] rdv(input logic [7:0] c, input logic [7:0] i);
		return (c == 8'h30 && i == 8'h00) ? 8'h02 : {i[3:0], c[3:0]};
	endfunction
	// register set answers in the same cycle
	assign rd_len = (rd_cmd == 8'h30) ? 8'h03 : (rd_cmd == 8'h26) ? 8'h02 : 8'h01;
	cmd_slave #(.GUARD_CYC(200)) uut (.clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .rd_cmd, .rd_index, .rd_data(rdv(rd_cmd, rd_index)), .rd_len, .wr_beat,
		.wr_valid, .wr_ready, .clear_faults, .cfg_one, .guard_tripped);
	bus_master m (.clk, .sda, .scl_q(scl), .sda_q(sda_m));
	always @(posedge clk) begin
		if (wr_valid === 1'b1 && wr_ready) beats.push_back(wr_beat);
		if (clear_faults === 1'b1) clears <= clears + 1;
		if (guard_tripped === 1'b1) trips <= trips + 1;
	end
	task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic hdr(input logic rw);
		m.wbyte({cmd_slave_pkg::DEV_ADDR_DEFAULT, rw}, ack);
		cmp("addr ack", 1, ack);
	endtask
	task automatic wr(input logic [7:0] d);
		m.wbyte(d, ack);
		cmp("byte ack", 1, ack);
	endtask
	task automatic beat(input logic [23:0] e);
		cmp("beat", e, beats.size() > 0 ? beats.pop_front() : 24'hFFFFFF);
	endtask
	task automatic t_basic();
		cmp("cfg reset", cmd_slave_pkg::CFG_ONE_RESET, cfg_one);
		m.start();
		hdr(1'b0);
		wr(cmd_slave_pkg::CMD_CLEAR_FAULTS);
		m.stop();
		repeat (10) @(posedge clk);
		cmp("clears", 1, clears);
		m.start();
		m.wbyte({cmd_slave_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
		cmp("foreign ack", 0, ack);
		m.stop();
		$display("end basic");
	endtask
	task automatic t_writes();
		beats.delete();
		m.start();
		hdr(1'b0);
		wr(8'h40);
		wr(8'hA5);
		m.stop();
		m.start();
		hdr(1'b0);
		wr(8'h41);
		wr(8'h3C);
		wr(8'hC3);
		m.stop();
		repeat (10) @(posedge clk);
		beat({8'h40, 8'hA5, 8'h00});
		beat({8'h41, 8'h3C, 8'h00});
		beat({8'h41, 8'hC3, 8'h01});
		$display("end writes");
	endtask
	// stalled far side: buffer must refuse the beat after its 32nd
	task automatic t_fill();
		@(posedge clk) wr_ready <= 1'b0;
		m.start();
		hdr(1'b0);
		wr(8'h50);
		wr(8'h28);
		k = 0;
		ack = 1'b1;
		while (ack && k < 40) begin
			m.wbyte(k[7:0], ack);
			if (ack) k++;
		end
		m.stop();
		cmp("taken", 31, k);
		@(posedge clk) wr_ready <= 1'b1;
		for (int i = 0; i < 300 && wr_valid !== 1'b0; i++) @(posedge clk);
		cmp("drained", 0, wr_valid);
		if (wr_valid !== 1'b0) report_and_stop();
		beat({8'h50, 8'h28, 8'h00});
		for (int i = 0; i < 31; i++) beat({8'h50, i[7:0], i[7:0] + 8'h01});
		$display("end fill");
	endtask
	task automatic t_read(input logic [7:0] c, input int n);
		m.start();
		hdr(1'b0);
		wr(c);
		m.start();
		hdr(1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i == n - 1, b);
			cmp("read", rdv(c, i[7:0]), b);
		end
		m.stop();
		$display("end read");
	endtask
	task automatic t_guard();
		m.start();
		hdr(1'b0);
		repeat (400) @(posedge clk);
		m.stop();
		cmp("trips off", 0, trips);
		m.start();
		hdr(1'b0);
		wr(cmd_slave_pkg::CFG_ONE_OFFSET);
		wr(8'h08);
		m.stop();
		repeat (10) @(posedge clk);
		cmp("cfg", 8'h08, cfg_one);
		m.start();
		hdr(1'b0);
		repeat (400) @(posedge clk);
		cmp("trips on", 1, trips);
		cmp("released", 0, sda_oe);
		m.stop();
		$display("end guard");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_basic();
		t_writes();
		t_fill();
		t_read(8'h15, 1);
		t_read(8'h26, 2);
		t_read(8'h30, 3);
		t_guard();
		report_and_stop();
	end
endmodule
